// ### dv/dht_drive_model.sv
/* Motor and bridge stand-in: armature current and stop completion.
   Assumes the latch's firing, contactor and stop request outputs. */
`timescale 1ns/1ns
`default_nettype none
module dht_drive_model #(
    parameter int STOP_CYC = 6
) (
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic        fire_enable_in,
    input  wire logic        contactor_in,
    input  wire logic        ctrl_stop_req_in,
    input  wire logic        slow_in,
    input  wire logic [15:0] load_in,
    output var  logic [15:0] arm_current_out,
    output var  logic        stop_done_out
);
    // ----------
    // Motor
    // ----------
    int stop_cnt_r;
    always_ff @(posedge mclk_in) begin
        if (!resetn_in || !ctrl_stop_req_in) begin
            stop_cnt_r <= 0;
        end else if (stop_cnt_r < STOP_CYC) begin
            stop_cnt_r <= stop_cnt_r + 1;
        end
    end
    // No current without both firing and contactor
    always_ff @(posedge mclk_in) begin
        arm_current_out <= (fire_enable_in && contactor_in) ? load_in : 16'h0000;
    end
    assign stop_done_out = ctrl_stop_req_in && (stop_cnt_r >= (slow_in ? STOP_CYC : 1));
endmodule // dht_drive_model
`default_nettype wire

// ### dv/dht_trip_latch_tb.sv
/* Self-checking bench for the drive trip latch.
   Assumes dht_params.svh on the include path and the drive model beside it. */
`timescale 1ns/1ns
`default_nettype none
`include "dht_params.svh"
`define CHK(act, exp, msg) begin checked++; if ((act) !== (exp)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, msg); end end
module dht_trip_latch_tb;
    logic        mclk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [15:0] alarm_in = 16'h0000;
    logic        run_in = 1'b0;
    logic        enable_in = 1'b0;
    logic        prog_stop_in = 1'b1;
    logic        coast_stop_in = 1'b1;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [15:0] load_r = 16'h0000;
    logic        slow_r = 1'b1;
    logic        stop_done_in, healthy_out, dig_out2_out, fire_enable_out, contactor_out;
    logic        start_contactor_out, ctrl_stop_req_out, run_led_out, health_led_out;
    logic        oc_trip_led_out, irq_out;
    logic [15:0] arm_current_in, reg_rdata_out, rd_v;
    logic [4:0]  panel_fault_code_out;
    int          err_total = 0;
    int          checked = 0;

    always #20 mclk_in = ~mclk_in;

    dht_trip_latch dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .alarm_in(alarm_in),
        .run_in(run_in), .enable_in(enable_in), .prog_stop_in(prog_stop_in),
        .coast_stop_in(coast_stop_in), .stop_done_in(stop_done_in),
        .arm_current_in(arm_current_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .healthy_out(healthy_out),
        .dig_out2_out(dig_out2_out), .fire_enable_out(fire_enable_out),
        .contactor_out(contactor_out), .start_contactor_out(start_contactor_out),
        .ctrl_stop_req_out(ctrl_stop_req_out), .run_led_out(run_led_out),
        .health_led_out(health_led_out), .oc_trip_led_out(oc_trip_led_out),
        .panel_fault_code_out(panel_fault_code_out), .irq_out(irq_out));
    dht_drive_model model_u (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .fire_enable_in(fire_enable_out), .contactor_in(contactor_out),
        .ctrl_stop_req_in(ctrl_stop_req_out), .slow_in(slow_r), .load_in(load_r),
        .arm_current_out(arm_current_in), .stop_done_out(stop_done_in));

    // ----------
    // Helpers
    // ----------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        tick(1);
        reg_wr_in <= 1'b0;
        tick(1);
    endtask
    // Data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        tick(1);
        reg_rd_in <= 1'b0;
        tick(1);
        d = reg_rdata_out;
    endtask
    task automatic start();
        run_in <= 1'b1;
        enable_in <= 1'b1;
        tick(6);
    endtask
    task automatic halt(input int n);
        alarm_in <= 16'h0000;
        load_r <= 16'h0000;
        run_in <= 1'b0;
        prog_stop_in <= 1'b1;
        coast_stop_in <= 1'b1;
        tick(n);
    endtask
    task automatic end_sim();
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_regs();
        reg_rd(`DHT_REG_CTRL, rd_v);
        `CHK(rd_v, 16'h0001, "ctrl reset")
        reg_rd(`DHT_REG_FLC, rd_v);
        `CHK(rd_v, `DHT_FLC_RST, "flc reset")
        reg_wr(`DHT_REG_FAULT, 16'hFFFF);
        reg_wr(4'hF, 16'hFFFF);
        reg_rd(`DHT_REG_FAULT, rd_v);
        `CHK(rd_v, 16'h0000, "fault code reset")
        reg_rd(4'hF, rd_v);
        `CHK(rd_v, 16'h0000, "unmapped read")
        `CHK(healthy_out, 1'b1, "idle healthy")
    endtask
    task automatic t_alarms();
        for (int i = 0; i < 16; i++) begin
            start();
            `CHK(run_led_out, 1'b1, "run led")
            alarm_in <= 16'h0001 << i;
            tick(4);
            `CHK({healthy_out, fire_enable_out, run_led_out}, 3'b000, "trip")
            `CHK(contactor_out, 1'b1, "held")
            `CHK(panel_fault_code_out, 5'(i + 1), "fault code")
            tick(1);
            `CHK(contactor_out, 1'b0, "contactor")
            alarm_in <= 16'h0000;
            tick(6);
            `CHK(healthy_out, 1'b0, "held until run low")
            halt(6);
            `CHK(healthy_out, 1'b1, "released")
        end
    endtask
    task automatic t_live_restart();
        start();
        alarm_in <= 16'h0008;
        tick(5);
        run_in <= 1'b0;
        tick(5);
        start();
        `CHK({healthy_out, contactor_out, fire_enable_out}, 3'b000, "restart")
        halt(8);
    endtask
    task automatic t_no_autoclr();
        reg_wr(`DHT_REG_CTRL, 16'h0000);
        start();
        alarm_in <= 16'h0001;
        tick(5);
        halt(6);
        start();
        `CHK({healthy_out, contactor_out, fire_enable_out}, 3'b000, "blocked")
        halt(2);
        resetn_in <= 1'b0;
        tick(2);
        resetn_in <= 1'b1;
        tick(2);
        `CHK(panel_fault_code_out, 5'h00, "code cleared")
    endtask
    task automatic t_overcur();
        reg_wr(`DHT_REG_INT_STAT, 16'h000F);
        load_r <= 16'h0300;
        start();
        `CHK(healthy_out, 1'b1, "at limit")
        load_r <= 16'h0301;
        tick(4);
        `CHK(panel_fault_code_out, 5'd17, "overcurrent code")
        `CHK(irq_out, 1'b0, "masked irq")
        reg_rd(`DHT_REG_INT_STAT, rd_v);
        `CHK(rd_v[3:0], 4'b0011, "int status")
        reg_wr(`DHT_REG_INT_MASK, 16'h0003);
        tick(1);
        `CHK(irq_out, 1'b1, "irq raised")
        reg_wr(`DHT_REG_INT_STAT, 16'h000F);
        tick(1);
        `CHK(irq_out, 1'b0, "irq cleared")
        halt(6);
    endtask
    // Slow stop via stop interlock, prompt stop via run low
    task automatic t_stops();
        start();
        prog_stop_in <= 1'b0;
        tick(4);
        `CHK({ctrl_stop_req_out, contactor_out}, 2'b11, "stopping")
        tick(8);
        `CHK(contactor_out, 1'b0, "stopped")
        halt(2);
        slow_r <= 1'b0;
        start();
        run_in <= 1'b0;
        tick(6);
        `CHK({start_contactor_out, contactor_out}, 2'b00, "run low")
        start();
        coast_stop_in <= 1'b0;
        tick(4);
        `CHK({contactor_out, ctrl_stop_req_out}, 2'b00, "coast")
        halt(4);
        start();
        enable_in <= 1'b0;
        tick(4);
        `CHK({run_led_out, fire_enable_out}, 2'b00, "bridge off")
        enable_in <= 1'b1;
        halt(8);
    endtask

    initial begin
        #(40 * 8000);
        err_total++;
        end_sim();
    end
    initial begin
        tick(2);
        resetn_in <= 1'b1;
        tick(4);
        t_regs();
        t_alarms();
        t_live_restart();
        t_no_autoclr();
        t_overcur();
        t_stops();
        end_sim();
    end
endmodule // dht_trip_latch_tb
`default_nettype wire

// ### dv/dht_trip_monitor.sv
/* Port checker for the drive trip latch.
   Bound to dht_trip_latch; assumes the full load register keeps its reset value. */
`timescale 1ns/1ns
`default_nettype none
module dht_trip_monitor (
    input wire logic        mclk_in,
    input wire logic        resetn_in,
    input wire logic [15:0] alarm_in,
    input wire logic        run_in,
    input wire logic        coast_stop_in,
    input wire logic        stop_done_in,
    input wire logic [15:0] arm_current_in,
    input wire logic        healthy_out,
    input wire logic        dig_out2_out,
    input wire logic        fire_enable_out,
    input wire logic        contactor_out,
    input wire logic        start_contactor_out,
    input wire logic        ctrl_stop_req_out,
    input wire logic        run_led_out,
    input wire logic        health_led_out,
    input wire logic        oc_trip_led_out,
    input wire logic [4:0]  panel_fault_code_out,
    input wire logic        irq_out
);
    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    a_dig_out_copy: assert property (dig_out2_out == healthy_out)
        else $error("dig out differs");
    a_health_led_copy: assert property (health_led_out == healthy_out)
        else $error("health led differs");
    a_fire_needs_health: assert property (!healthy_out |-> !fire_enable_out)
        else $error("firing enabled while unhealthy");
    // Two sync flops plus the output flop
    a_alarm_trip_time: assert property (($rose(|alarm_in) && run_led_out) |->
        ##[2:3] (!healthy_out && !fire_enable_out && panel_fault_code_out != 5'h00))
        else $error("alarm did not trip in time");
    a_contactor_after: assert property (($fell(fire_enable_out) && !healthy_out) |->
        contactor_out ##1 !contactor_out) else $error("contactor order");
    a_no_live_restart: assert property ($rose(contactor_out) |-> healthy_out)
        else $error("contactor closed while unhealthy");
    // Threshold is 300 percent of the reset full load value
    a_oc_level: assert property ($past(resetn_in) |->
        oc_trip_led_out == ($past(arm_current_in) > 16'h0300))
        else $error("overcurrent indication wrong");
    a_cstop_release: assert property (($fell(contactor_out) && $past(ctrl_stop_req_out) &&
        coast_stop_in && healthy_out) |-> $past(stop_done_in)) else $error("early drop");
    a_coast_drop: assert property (!coast_stop_in [*4] |-> !contactor_out)
        else $error("held in coast");
    a_start_open: assert property (!run_in [*4] |-> !start_contactor_out)
        else $error("start contactor closed without run");
    a_run_led_gate: assert property (run_led_out |-> (start_contactor_out &&
        contactor_out && fire_enable_out && healthy_out)) else $error("run led without cause");
    a_reset_safe: assert property ($rose(resetn_in) |-> (!contactor_out &&
        !fire_enable_out && panel_fault_code_out == 5'h00)) else $error("unsafe after reset");

    c_trip: cover property ($fell(healthy_out));
    c_cstop_done: cover property (ctrl_stop_req_out ##1 !ctrl_stop_req_out);
    c_coast: cover property (!coast_stop_in ##1 $fell(contactor_out));
    c_irq: cover property ($rose(irq_out));
endmodule // dht_trip_monitor

bind dht_trip_latch dht_trip_monitor mon_u (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .alarm_in(alarm_in), .run_in(run_in),
    .coast_stop_in(coast_stop_in), .stop_done_in(stop_done_in),
    .arm_current_in(arm_current_in), .healthy_out(healthy_out),
    .dig_out2_out(dig_out2_out), .fire_enable_out(fire_enable_out),
    .contactor_out(contactor_out), .start_contactor_out(start_contactor_out),
    .ctrl_stop_req_out(ctrl_stop_req_out), .run_led_out(run_led_out),
    .health_led_out(health_led_out), .oc_trip_led_out(oc_trip_led_out),
    .panel_fault_code_out(panel_fault_code_out), .irq_out(irq_out));
`default_nettype wire

// ### hw/dht_params.svh
/*
 * Register offsets, field positions, reset values and limits for the
 * drive health trip latch.
 * Assumes a 4-bit word address and 16-bit register data.
 */
`ifndef DHT_PARAMS_SVH
`define DHT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (word addresses)
// ----------------------------------------------------------------------
`define DHT_REG_CTRL      4'h0
`define DHT_REG_STATUS    4'h1
`define DHT_REG_ALARM_LO  4'h2
`define DHT_REG_ALARM_HI  4'h3
`define DHT_REG_FAULT     4'h4
`define DHT_REG_FLC       4'h5
`define DHT_REG_INT_STAT  4'h6
`define DHT_REG_INT_MASK  4'h7

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define DHT_CTRL_AUTOCLR  0
`define DHT_CTRL_RST      1'h1
`define DHT_FLC_RST       16'h0100
`define DHT_INT_TRIP      0
`define DHT_INT_OVERCUR   1
`define DHT_INT_COAST     2
`define DHT_INT_STOPPED   3

// ----------------------------------------------------------------------
// Alarm set and overcurrent limit
// ----------------------------------------------------------------------
`define DHT_NUM_ALARMS    17
`define DHT_EXT_ALARMS    16
`define DHT_OC_PCT        26'h000012C
`define DHT_PCT_BASE      26'h0000064

`endif

// ### hw/dht_pkg.sv
/*
 * Types shared by the drive health trip latch files.
 * Assumes the constants of dht_params.svh.
 */
package dht_pkg;

    // Drive sequencing states
    typedef enum logic [1:0] {
        DHT_IDLE,
        DHT_RUNNING,
        DHT_CSTOP,
        DHT_TRIPPED
    } dht_state_type;

    typedef logic [15:0] dht_word_type;
    typedef logic [4:0]  dht_code_type;

endpackage

// ### hw/dht_sync.sv
/*
 * Two-flop synchroniser for a vector of pin levels.
 * Assumes each bit is an independent slow level; no bus coherency.
 */
`timescale 1ns/1ns
`default_nettype none

module dht_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // dht_sync

`default_nettype wire

// ### hw/dht_trip_latch.sv
/*
 * Fault supervision and trip latch for a DC motor drive: alarm summary,
 * firing inhibit, contactor control, stop inputs, overcurrent trip,
 * fault capture for the operator panel, register port and interrupt.
 * Assumes pins are asynchronous, current and stop-done come from logic
 * on mclk_in, and a register master that never waits.
 */
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "dht_params.svh"

// Summary of operation
// - Seventeen alarms combine into one healthy flag
// - Healthy flag is the alarm summary output
// - Healthy flag drives digital output two
// - Fault drops healthy, inhibits firing at once
// - Then contactor drops (with firing if coast-stop low), fault captured for panel
// - Auto-clear: trip held until run goes low
// - Restart into live fault re-trips, no enable
// - No auto-clear: restart blocked after any trip
// - Overcurrent trips above 300 percent full load
// - Controlled-stop low: stop, then drop contactor
// - Coast-stop low: drop contactor immediately
// - Start contactor open while run is low
// - Run indication false on disable or alarm
// - Health indication off on any fault
// - Run on: start, contactor, bridge, healthy
module dht_trip_latch
    import dht_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic [15:0] alarm_in,
    input  wire logic        run_in,
    input  wire logic        enable_in,
    input  wire logic        prog_stop_in,
    input  wire logic        coast_stop_in,
    input  wire logic        stop_done_in,
    input  wire logic [15:0] arm_current_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output var  logic [15:0] reg_rdata_out,
    output var  logic        healthy_out,
    output var  logic        dig_out2_out,
    output var  logic        fire_enable_out,
    output var  logic        contactor_out,
    output var  logic        start_contactor_out,
    output var  logic        ctrl_stop_req_out,
    output var  logic        run_led_out,
    output var  logic        health_led_out,
    output var  logic        oc_trip_led_out,
    output var  logic [4:0]  panel_fault_code_out,
    output var  logic        irq_out
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Current above limit, compared in percent to avoid a divider
    function automatic logic over_limit(input logic [15:0] cur,
                                        input logic [15:0] flc);
        logic [25:0] lhs;
        logic [25:0] rhs;
        lhs = 26'(cur) * `DHT_PCT_BASE;
        rhs = 26'(flc) * `DHT_OC_PCT;
        return lhs > rhs;
    endfunction

    // Lowest active alarm as code 1..17, zero when none
    function automatic dht_code_type first_alarm(
        input logic [`DHT_NUM_ALARMS-1:0] a);
        dht_code_type c;
        c = 5'h00;
        for (int i = `DHT_NUM_ALARMS - 1; i >= 0; i--) begin
            if (a[i]) begin
                c = 5'(i + 1);
            end
        end
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [19:0]                pin_sync;
    logic [15:0]                ext_alarm;
    logic                       run_s;
    logic                       enable_s;
    logic                       prog_s;
    logic                       coast_s;
    logic                       overcur;
    logic [`DHT_NUM_ALARMS-1:0] alarm_vec;
    logic                       any_alarm;
    logic                       start_ok;
    logic                       trip_event;

    dht_state_type              state_r;
    dht_state_type              state_nxt;
    logic                       trip_r;
    logic [`DHT_NUM_ALARMS-1:0] alarm_r;
    dht_code_type               fault_code_r;
    logic                       auto_clear_r;
    dht_word_type               flc_r;
    logic [3:0]                 int_stat_r;
    logic [3:0]                 int_stat_nxt;
    logic [3:0]                 int_mask_r;
    logic [3:0]                 int_event;
    logic                       coast_q_r;
    logic                       running_now;
    logic                       healthy_nxt;
    logic                       fire_nxt;
    logic                       contactor_nxt;
    logic                       start_ct_nxt;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    dht_sync #(
        .W (20)
    ) u_pin_sync (
        .mclk_in   (mclk_in),
        .resetn_in (resetn_in),
        .async_in  ({coast_stop_in, prog_stop_in, enable_in, run_in, alarm_in}),
        .sync_out  (pin_sync)
    );

    assign ext_alarm = pin_sync[15:0];
    assign run_s     = pin_sync[16];
    assign enable_s  = pin_sync[17];
    assign prog_s    = pin_sync[18];
    assign coast_s   = pin_sync[19];

    // ------------------------------------------------------------------
    // Alarm summary
    // ------------------------------------------------------------------
    assign overcur   = over_limit(arm_current_in, flc_r);
    assign alarm_vec = {overcur, ext_alarm};
    assign any_alarm = |alarm_vec;

    // Start needs no latched trip; a live alarm at start re-trips instead
    assign start_ok  = run_s && prog_s && coast_s && !trip_r;

    // Alarms are watched while running and at any attempted start
    assign trip_event = any_alarm &&
                        (state_r == DHT_RUNNING || state_r == DHT_CSTOP ||
                         (state_r == DHT_IDLE && start_ok));

    assign running_now = (state_nxt == DHT_RUNNING) || (state_nxt == DHT_CSTOP);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DHT_IDLE: begin
                if (trip_event) begin
                    state_nxt = DHT_TRIPPED;
                end else if (start_ok) begin
                    state_nxt = DHT_RUNNING;
                end
            end
            DHT_RUNNING: begin
                if (trip_event) begin
                    state_nxt = DHT_TRIPPED;
                end else if (!coast_s) begin
                    state_nxt = DHT_IDLE;
                end else if (!prog_s || !run_s) begin
                    state_nxt = DHT_CSTOP;
                end
            end
            DHT_CSTOP: begin
                if (trip_event) begin
                    state_nxt = DHT_TRIPPED;
                end else if (!coast_s || stop_done_in) begin
                    state_nxt = DHT_IDLE;
                end
            end
            DHT_TRIPPED: begin
                // Without auto-clear only reset leaves this state
                if (auto_clear_r && !run_s) begin
                    state_nxt = DHT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            state_r <= DHT_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Trip latch and fault capture
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            trip_r       <= 1'b0;
            fault_code_r <= 5'h00;
            alarm_r      <= '0;
        end else begin
            alarm_r <= alarm_vec;
            if (trip_event) begin
                trip_r       <= 1'b1;
                fault_code_r <= first_alarm(alarm_vec);
            end else if (state_r == DHT_TRIPPED && auto_clear_r && !run_s) begin
                trip_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Drive outputs
    // ------------------------------------------------------------------
    // Healthy falls in the cycle the alarm is seen and stays low while tripped
    assign healthy_nxt   = !any_alarm && !trip_event &&
                           !(trip_r && state_nxt == DHT_TRIPPED);
    assign fire_nxt      = running_now && enable_s && !trip_event;
    // Contactor drops one cycle after firing on a trip with coast-stop high, otherwise with it; never before it
    assign contactor_nxt = (contactor_out && (running_now || (trip_event && coast_s))) ||
                           (state_r == DHT_IDLE && state_nxt == DHT_RUNNING);
    assign start_ct_nxt  = run_s && !trip_event &&
                           !(trip_r && state_nxt == DHT_TRIPPED);

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            healthy_out         <= 1'b0;
            dig_out2_out        <= 1'b0;
            fire_enable_out     <= 1'b0;
            contactor_out       <= 1'b0;
            start_contactor_out <= 1'b0;
            ctrl_stop_req_out   <= 1'b0;
            health_led_out      <= 1'b0;
            oc_trip_led_out     <= 1'b0;
        end else begin
            healthy_out         <= healthy_nxt;
            dig_out2_out        <= healthy_nxt;
            health_led_out      <= healthy_nxt;
            fire_enable_out     <= fire_nxt;
            contactor_out       <= contactor_nxt && !(trip_r && !running_now);
            start_contactor_out <= start_ct_nxt;
            ctrl_stop_req_out   <= (state_nxt == DHT_CSTOP);
            oc_trip_led_out     <= overcur;
        end
    end

    // Run light is built from the next values of the outputs it reports on
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            run_led_out <= 1'b0;
        end else begin
            run_led_out <= run_s && start_ct_nxt && fire_nxt &&
                           contactor_nxt && healthy_nxt && !any_alarm;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            panel_fault_code_out <= 5'h00;
        end else begin
            panel_fault_code_out <= trip_event ? first_alarm(alarm_vec)
                                               : fault_code_r;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            auto_clear_r <= `DHT_CTRL_RST;
            flc_r        <= `DHT_FLC_RST;
            int_mask_r   <= 4'h0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `DHT_REG_CTRL) begin
                auto_clear_r <= reg_wdata_in[`DHT_CTRL_AUTOCLR];
            end
            if (reg_addr_in == `DHT_REG_FLC) begin
                flc_r <= reg_wdata_in;
            end
            if (reg_addr_in == `DHT_REG_INT_MASK) begin
                int_mask_r <= reg_wdata_in[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            coast_q_r <= 1'b0;
        end else begin
            coast_q_r <= coast_s;
        end
    end

    always_comb begin
        int_event = 4'h0;
        int_event[`DHT_INT_TRIP]    = trip_event;
        int_event[`DHT_INT_OVERCUR] = overcur && !alarm_r[`DHT_EXT_ALARMS];
        int_event[`DHT_INT_COAST]   = coast_q_r && !coast_s;
        int_event[`DHT_INT_STOPPED] = state_r == DHT_CSTOP && state_nxt == DHT_IDLE;
    end

    // New events win over a same-cycle write-one-to-clear
    always_comb begin
        int_stat_nxt = int_stat_r;
        if (reg_wr_in && reg_addr_in == `DHT_REG_INT_STAT) begin
            int_stat_nxt = int_stat_nxt & ~reg_wdata_in[3:0];
        end
        int_stat_nxt = int_stat_nxt | int_event;
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            int_stat_r <= 4'h0;
            irq_out    <= 1'b0;
        end else begin
            int_stat_r <= int_stat_nxt;
            irq_out    <= |(int_stat_nxt & int_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `DHT_REG_CTRL:     reg_rdata_out <= {15'h0000, auto_clear_r};
                `DHT_REG_STATUS:   reg_rdata_out <= {9'h000, state_r, contactor_out,
                                                     fire_enable_out, run_led_out,
                                                     trip_r, healthy_out};
                `DHT_REG_ALARM_LO: reg_rdata_out <= alarm_r[15:0];
                `DHT_REG_ALARM_HI: reg_rdata_out <= {15'h0000, alarm_r[16]};
                `DHT_REG_FAULT:    reg_rdata_out <= {11'h000, fault_code_r};
                `DHT_REG_FLC:      reg_rdata_out <= flc_r;
                `DHT_REG_INT_STAT: reg_rdata_out <= {12'h000, int_stat_r};
                `DHT_REG_INT_MASK: reg_rdata_out <= {12'h000, int_mask_r};
                default:           reg_rdata_out <= 16'h0000;
            endcase
        end else begin
            // Data stand only in the cycle after the read strobe
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule // dht_trip_latch

`default_nettype wire
